/* rtl/flash_seq_pkg.sv */
// Constants shared by the flash self-programming sequencer and its bench.
// Assumes a single 100 MHz core clock and a byte-wide register port.
package flash_seq_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STAT_ADDR = 4'h1;
	localparam logic [3:0] MASK_ADDR = 4'h2;

	// Control register fields.
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_RWWE_BIT = 4;
	localparam int CTRL_BUSY_BIT = 6;
	localparam int CTRL_IE_BIT   = 7;

	// Command codes in bits 5:0; bit 6 is read-only busy, bit 7 the interrupt enable.
	localparam logic [5:0] CMD_LOAD   = 6'h01;
	localparam logic [5:0] CMD_ERASE  = 6'h03;
	localparam logic [5:0] CMD_WRITE  = 6'h05;
	localparam logic [5:0] CMD_RWW_EN = 6'h11;
	localparam logic [5:0] CMD_NONE   = 6'h00;

	// Sticky event bits of the status and mask registers.
	localparam int EV_DONE    = 0;
	localparam int EV_DISCARD = 1;
	localparam int EV_TIMEOUT = 2;
	localparam int EV_COUNT   = 3;

	// Reset values.
	localparam logic [7:0]          RDATA_RESET = 8'h00;
	localparam logic [EV_COUNT-1:0] EV_RESET    = 3'h0;

	// Cycles between the control write and the store-program instruction.
	localparam int ARM_WINDOW = 4;

	// Least flash programming time, rounded up to whole clock cycles.
	// Counted in nanoseconds so that the sum stays inside a 32-bit int.
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS  = 3_700_000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		S_IDLE,
		S_ARMED,
		S_PROG
	} seq_state_e;

endpackage : flash_seq_pkg

/* rtl/flash_page_buffer.sv */
// Temporary page buffer: one word per entry, each entry loadable once per clear.
// Assumes all controls come from logic on the same clock.
`timescale 1ns/1ps
module flash_page_buffer #(
	parameter int WORDS     = 32,
	parameter int IDX_BITS  = 5,
	parameter int DATA_BITS = 16
) (
	// Clock and control.
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	input  wire logic                 clear,
	// Load side.
	input  wire logic                 wr_en,
	input  wire logic [IDX_BITS-1:0]  wr_idx,
	input  wire logic [DATA_BITS-1:0] wr_data,
	// Read side toward the flash array.
	input  wire logic [IDX_BITS-1:0]  rd_idx,
	output logic      [DATA_BITS-1:0] rd_data,
	output logic                      any_loaded
);

	logic [DATA_BITS-1:0] mem [WORDS];
	logic [WORDS-1:0]     loaded;

	// Unloaded entries read as erased flash.
	genvar g;
	generate
		for (g = 0; g < WORDS; g++) begin : g_entry
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					loaded[g] <= 1'b0;
				end else if (clk_en) begin
					if (clear) begin
						loaded[g] <= 1'b0;
					end else if (wr_en && wr_idx == IDX_BITS'(g) && !loaded[g]) begin
						loaded[g] <= 1'b1;
						mem[g]    <= wr_data;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= '0;
		end else if (clk_en) begin
			rd_data <= loaded[rd_idx] ? mem[rd_idx] : '1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			any_loaded <= 1'b0;
		end else if (clk_en) begin
			any_loaded <= !clear && (|loaded || wr_en);
		end
	end

	AST_SECOND_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && wr_en && !clear && loaded[wr_idx]
		|=> mem[$past(wr_idx)] == $past(mem[wr_idx]))
		else $error("A loaded buffer entry was overwritten.");

endmodule : flash_page_buffer

/* rtl/flash_self_program_sequencer.sv */
// Self-programming sequencer: control register, command window, page buffer
// loads, page erase and write timing, section blocking and interrupts.
// Assumes the core, the data EEPROM and the flash array share sys_clk.
//
// Notes on behaviour
// - Buffer entry chosen by word index field.
// - Buffer cleared after page write or read-enable write.
// - Buffer cleared by system reset.
// - Each buffer entry loads once per clear.
// - EEPROM write during loading discards loaded words.
// - Page write ignores the data pair.
// - Rewritable target keeps fixed section readable.
// - Fixed-section target stalls the core until done.
// - Ready request held while enable reads cleared.
// - Erase and write block rewritable section reads.
// - Busy flag set while rewritable section occupied.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module flash_self_program_sequencer
	import flash_seq_pkg::*;
#(
	parameter int Z_BITS           = 16,
	parameter int WORD_BITS        = 5,
	parameter int FIXED_FIRST_PAGE = 768,
	parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
	// Clock, reset and clock enable.
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        clk_en,
	// Register port.
	input  wire logic [3:0]                  reg_addr,
	input  wire logic [7:0]                  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [7:0]                  reg_rdata,
	// Core side.
	input  wire logic                        store_program_instruction,
	input  wire logic [Z_BITS-1:0]           pointer_pair,
	input  wire logic [15:0]                 program_data_pair,
	input  wire logic                        eeprom_write,
	output logic                             cpu_stall,
	output logic                             rewritable_read_block,
	output logic                             spm_ready_irq,
	output logic                             irq,
	// Flash array side.
	output logic                             flash_start,
	output logic                             flash_erase,
	output logic [Z_BITS-WORD_BITS-2:0]      flash_page_index,
	input  wire logic [WORD_BITS-1:0]        flash_buf_idx,
	output logic      [15:0]                 flash_buf_data
);

	localparam int PAGE_BITS = Z_BITS - WORD_BITS - 1;
	localparam int TMR_BITS  = $clog2(PROG_TIME_CYCLES + 1);
	localparam logic [2:0]           WIN_LAST  = 3'(ARM_WINDOW - 1);
	localparam logic [TMR_BITS-1:0]  TMR_LAST  = TMR_BITS'(PROG_TIME_CYCLES - 1);
	localparam logic [PAGE_BITS-1:0] FIXED_PG  = PAGE_BITS'(FIXED_FIRST_PAGE);

	seq_state_e            seq_state;
	logic [5:0]            ctrl_cmd;
	logic                  ctrl_ie;
	logic                  busy_flag;
	logic [2:0]            win_cnt;
	logic [TMR_BITS-1:0]   tmr;
	logic                  op_fixed;
	logic                  op_write;
	logic [EV_COUNT-1:0]   ev_status;
	logic [EV_COUNT-1:0]   ev_mask;
	logic [EV_COUNT-1:0]   ev_set;
	logic                  any_loaded;

	logic                  ctrl_wr;
	logic                  accept;
	logic                  win_miss;
	logic                  prog_done;
	logic                  buf_wr;
	logic                  buf_clear;
	logic [WORD_BITS-1:0]  z_word;
	logic [PAGE_BITS-1:0]  z_page;
	logic                  z_fixed;

	assign ctrl_wr  = reg_wr && reg_addr == CTRL_ADDR;
	assign z_word   = pointer_pair[WORD_BITS:1];
	// The page field alone selects the target; low bits are expected zero.
	assign z_page   = pointer_pair[Z_BITS-1:WORD_BITS+1];
	assign z_fixed  = z_page >= FIXED_PG;
	assign accept   = seq_state == S_ARMED && store_program_instruction;
	assign win_miss = seq_state == S_ARMED && !store_program_instruction
		&& win_cnt == WIN_LAST;
	assign prog_done = seq_state == S_PROG && tmr == TMR_LAST;
	assign buf_wr   = accept && ctrl_cmd == CMD_LOAD;

	// Clearing the buffer while the array is copying it would corrupt the page.
	always_comb begin
		buf_clear = 1'b0;
		if (prog_done && op_write) begin
			buf_clear = 1'b1;
		end else if (seq_state != S_PROG && ctrl_wr && reg_wdata[CTRL_RWWE_BIT]) begin
			buf_clear = 1'b1;
		end else if (eeprom_write && any_loaded) begin
			buf_clear = 1'b1;
		end
	end

	always_comb begin
		ev_set              = '0;
		ev_set[EV_DONE]     = prog_done || (accept && ctrl_cmd != CMD_NONE);
		ev_set[EV_DISCARD]  = eeprom_write && any_loaded && !(prog_done && op_write);
		ev_set[EV_TIMEOUT]  = win_miss;
	end

	flash_page_buffer #(
		.WORDS     (1 << WORD_BITS),
		.IDX_BITS  (WORD_BITS),
		.DATA_BITS (16)
	) u_page_buffer (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.clk_en     (clk_en),
		.clear      (buf_clear),
		.wr_en      (buf_wr),
		.wr_idx     (z_word),
		.wr_data    (program_data_pair),
		.rd_idx     (flash_buf_idx),
		.rd_data    (flash_buf_data),
		.any_loaded (any_loaded)
	);

	// Sequencer state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seq_state <= S_IDLE;
		end else if (clk_en) begin
			case (seq_state)
				S_IDLE: begin
					if (ctrl_wr && reg_wdata[CTRL_EN_BIT]) begin
						seq_state <= S_ARMED;
					end
				end
				S_ARMED: begin
					if (accept && (ctrl_cmd == CMD_ERASE || ctrl_cmd == CMD_WRITE)) begin
						seq_state <= S_PROG;
					end else if (accept || win_miss) begin
						seq_state <= S_IDLE;
					end
				end
				S_PROG: begin
					if (prog_done) begin
						seq_state <= S_IDLE;
					end
				end
				default: begin
					seq_state <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			win_cnt <= '0;
		end else if (clk_en) begin
			win_cnt <= seq_state == S_ARMED ? win_cnt + 3'h1 : 3'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tmr <= '0;
		end else if (clk_en) begin
			tmr <= seq_state == S_PROG ? tmr + TMR_BITS'(1) : '0;
		end
	end

	// Command bits: locked while programming, dropped on completion or a missed window.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_cmd <= CMD_NONE;
		end else if (clk_en) begin
			if (win_miss) begin
				ctrl_cmd <= CMD_NONE;
			end else if (prog_done || (accept && seq_state != S_PROG
				&& ctrl_cmd != CMD_ERASE && ctrl_cmd != CMD_WRITE)) begin
				ctrl_cmd <= CMD_NONE;
			end else if (ctrl_wr && seq_state == S_IDLE) begin
				ctrl_cmd <= reg_wdata[5:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_ie <= 1'b0;
		end else if (clk_en && ctrl_wr) begin
			ctrl_ie <= reg_wdata[CTRL_IE_BIT];
		end
	end

	// Target is latched at the instruction; the data pair never reaches here.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			op_fixed         <= 1'b0;
			op_write         <= 1'b0;
			flash_page_index <= '0;
			flash_erase      <= 1'b0;
		end else if (clk_en && accept && seq_state == S_ARMED) begin
			op_fixed         <= z_fixed;
			op_write         <= ctrl_cmd == CMD_WRITE;
			flash_page_index <= z_page;
			flash_erase      <= ctrl_cmd == CMD_ERASE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flash_start <= 1'b0;
		end else if (clk_en) begin
			flash_start <= accept && (ctrl_cmd == CMD_ERASE || ctrl_cmd == CMD_WRITE);
		end
	end

	// The busy flag outlives the operation until software re-enables reads.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_flag <= 1'b0;
		end else if (clk_en) begin
			if (accept && (ctrl_cmd == CMD_ERASE || ctrl_cmd == CMD_WRITE)) begin
				busy_flag <= 1'b1;
			end else if (accept && ctrl_cmd == CMD_RWW_EN) begin
				busy_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rewritable_read_block <= 1'b0;
		end else if (clk_en) begin
			rewritable_read_block <= (seq_state == S_PROG && !prog_done) || (accept
				&& (ctrl_cmd == CMD_ERASE || ctrl_cmd == CMD_WRITE));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpu_stall <= 1'b0;
		end else if (clk_en) begin
			if (accept && (ctrl_cmd == CMD_ERASE || ctrl_cmd == CMD_WRITE)) begin
				cpu_stall <= z_fixed;
			end else if (prog_done) begin
				cpu_stall <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			spm_ready_irq <= 1'b0;
		end else if (clk_en) begin
			spm_ready_irq <= ctrl_ie && !ctrl_cmd[CTRL_EN_BIT];
		end
	end

	// Status bits: a new event wins over a write-one clear in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ev_status <= EV_RESET;
		end else if (clk_en) begin
			ev_status <= ev_set | (ev_status & ~((reg_wr && reg_addr == STAT_ADDR)
				? reg_wdata[EV_COUNT-1:0] : EV_RESET));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ev_mask <= EV_RESET;
		end else if (clk_en && reg_wr && reg_addr == MASK_ADDR) begin
			ev_mask <= reg_wdata[EV_COUNT-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(ev_status & ev_mask);
		end
	end

	// Unmapped offsets read as zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= RDATA_RESET;
		end else if (clk_en) begin
			if (!reg_rd) begin
				reg_rdata <= RDATA_RESET;
			end else if (reg_addr == CTRL_ADDR) begin
				reg_rdata <= {ctrl_ie, busy_flag, ctrl_cmd};
			end else if (reg_addr == STAT_ADDR) begin
				reg_rdata <= {5'h00, ev_status};
			end else if (reg_addr == MASK_ADDR) begin
				reg_rdata <= {5'h00, ev_mask};
			end else begin
				reg_rdata <= RDATA_RESET;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !clk_en);

	AST_LOAD_INDEX: assert property (accept && ctrl_cmd == CMD_LOAD && !buf_clear
		|=> u_page_buffer.loaded[$past(pointer_pair[WORD_BITS:1])])
		else $error("Buffer load used the wrong index.");

	AST_CLEAR_ON_WRITE: assert property (prog_done && op_write |=> !any_loaded)
		else $error("Buffer not cleared after page write.");

	AST_CLEAR_ON_RESET: assert property (@(posedge sys_clk) disable iff (1'b0)
		rst |=> !any_loaded && seq_state == S_IDLE)
		else $error("Buffer not cleared by reset.");

	AST_EEPROM_DISCARD: assert property (eeprom_write && any_loaded
		|=> !any_loaded && ev_status[EV_DISCARD] || ev_status[EV_DONE])
		else $error("EEPROM write did not discard the buffer.");

	AST_FIXED_STALL: assert property (seq_state == S_PROG && op_fixed
		|-> cpu_stall ##0 rewritable_read_block)
		else $error("Core not stalled for fixed-section target.");

	AST_RWW_NO_STALL: assert property (seq_state == S_PROG && !op_fixed
		|-> !cpu_stall)
		else $error("Core stalled for rewritable target.");

	AST_READY_REQ: assert property ((ctrl_ie && !ctrl_cmd[CTRL_EN_BIT])[*2]
		|-> spm_ready_irq)
		else $error("Ready request missing while enable clear.");

	AST_BLOCK_BUSY: assert property ($rose(seq_state == S_PROG)
		|-> rewritable_read_block && busy_flag)
		else $error("Rewritable section not blocked during programming.");

	AST_WINDOW_MISS: assert property (seq_state == S_ARMED && !store_program_instruction
		&& win_cnt == WIN_LAST |=> seq_state == S_IDLE && ctrl_cmd == CMD_NONE)
		else $error("Missed window did not drop the command.");

	AST_ENABLE_CLEARS: assert property (accept && ctrl_cmd == CMD_LOAD
		|=> !ctrl_cmd[CTRL_EN_BIT] ##1 !ctrl_cmd[CTRL_EN_BIT] || seq_state != S_IDLE)
		else $error("Enable bit stayed set after a load.");

	COV_LOAD: cover property (buf_wr);
	COV_WRITE_DONE: cover property (prog_done && op_write);
	COV_TIMEOUT: cover property (win_miss);
	COV_FIXED_ERASE: cover property (flash_start && flash_erase && cpu_stall);

endmodule : flash_self_program_sequencer

/* test/core_model.sv */
// Core model: watches its own control write, then issues the store-program
// instruction a chosen number of cycles later, with pointer and data set up.
// Assumes the bench picks the lag, pointer and data before the control write.
`timescale 1ns/1ps
module core_model (
	// Clock.
	input  wire logic        sys_clk,
	// Snooped control write and scenario choice.
	input  wire logic        reg_wr,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic [2:0]  lag,
	input  wire logic [15:0] ptr,
	input  wire logic [15:0] dat,
	// Store-program side.
	output logic             store_program_instruction,
	output logic      [15:0] pointer_pair,
	output logic      [15:0] program_data_pair
);
	logic [2:0] cnt;

	initial begin
		store_program_instruction = 1'b0;
		cnt = 3'h0;
		pointer_pair = 16'h0000;
		program_data_pair = 16'h0000;
	end

	// Lag 1 to 4 lands inside the window; lag 0 never issues, to test a miss.
	// Loader pages are never targeted here, since no lock bit is modelled.
	always @(posedge sys_clk) begin
		if (reg_wr && reg_addr == 4'h0 && reg_wdata[0]) begin
			store_program_instruction <= (lag == 3'h1);
			cnt <= (lag == 3'h0) ? 3'h0 : lag - 3'h1;
			pointer_pair <= ptr;
			program_data_pair <= dat;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			store_program_instruction <= (cnt == 3'h1);
		end else begin
			store_program_instruction <= 1'b0;
			// Stale values are scrambled so nothing relies on them after use.
			pointer_pair <= ~pointer_pair;
			program_data_pair <= ~program_data_pair;
		end
	end
endmodule : core_model

/* test/tb.sv */
// Bench for the flash sequencer: a table of buffer loads, then hand-written cases.
// Assumes the core model issues the instruction and the programming time is 20.
`timescale 1ns/1ps
module tb
	import flash_seq_pkg::*;
;
	typedef struct packed {logic [15:0] p; logic [15:0] d; logic [15:0] e;} row_s;
	row_s rows [4] = '{'{16'h0000, 16'h1234, 16'h1234}, '{16'h003E, 16'hCAFE, 16'hCAFE},
		'{16'h0002, 16'h0F0F, 16'h0F0F}, '{16'h0004, 16'h8001, 16'h8001}};
	logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        eeprom_write = 1'b0, store_program_instruction;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata;
	logic [2:0]  lag = 3'h0;
	logic [4:0]  flash_buf_idx = 5'h00;
	logic [15:0] ptr = 16'h0000, dat = 16'h0000, pointer_pair, program_data_pair;
	logic [15:0] flash_buf_data;
	logic        cpu_stall, rewritable_read_block, spm_ready_irq, irq, flash_start, flash_erase;
	logic [9:0]  flash_page_index;
	int          n_fail = 0, checked = 0, cycles = 0;

	always #5 sys_clk = ~sys_clk;

	flash_self_program_sequencer #(.PROG_TIME_CYCLES(20)) flash_self_program_sequencer_i (
		.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.store_program_instruction, .pointer_pair, .program_data_pair, .eeprom_write,
		.cpu_stall, .rewritable_read_block, .spm_ready_irq, .irq, .flash_start,
		.flash_erase, .flash_page_index, .flash_buf_idx, .flash_buf_data);

	core_model core_model_i (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .lag, .ptr, .dat,
		.store_program_instruction, .pointer_pair, .program_data_pair);

	task automatic conclude();
		$display("checks=%0d failures=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic regis(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, e});
	endtask : regis

	task automatic op(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d, int l);
		lag = 3'(l);
		ptr = p;
		dat = d;
		wr(CTRL_ADDR, c);
		repeat (l) @(posedge sys_clk);
		#1;
	endtask : op

	task automatic buf_is(input logic [4:0] i, input logic [15:0] e);
		@(posedge sys_clk);
		flash_buf_idx <= i;
		@(posedge sys_clk);
		#1 chk(flash_buf_data, e);
	endtask : buf_is

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		regis(CTRL_ADDR, 8'h00);
		regis(STAT_ADDR, 8'h00);
		buf_is(5'h00, 16'hFFFF);
		wr(MASK_ADDR, 8'h04);
		for (int k = 0; k < 4; k++) begin
			op({2'b00, CMD_LOAD}, rows[k].p, rows[k].d, k + 1);
			buf_is(rows[k].p[5:1], rows[k].e);
		end
		op({2'b00, CMD_LOAD}, 16'h0000, 16'hBEEF, 2);
		buf_is(5'h00, 16'h1234);
		regis(CTRL_ADDR, 8'h00);
		chk(16'(irq), 16'h0000);
		// A missed window must drop the command and raise the masked event.
		op({2'b00, CMD_LOAD}, 16'h0000, 16'h0000, 0);
		repeat (6) @(posedge sys_clk);
		regis(CTRL_ADDR, 8'h00);
		regis(STAT_ADDR, 8'h05);
		chk(16'(irq), 16'h0001);
		wr(STAT_ADDR, 8'h07);
		regis(STAT_ADDR, 8'h00);
		chk(16'(irq), 16'h0000);
		@(posedge sys_clk);
		eeprom_write <= 1'b1;
		@(posedge sys_clk);
		eeprom_write <= 1'b0;
		buf_is(5'h1F, 16'hFFFF);
		regis(STAT_ADDR, 8'h02);
		op({2'b00, CMD_LOAD}, 16'h0006, 16'hA5A5, 4);
		op({2'b00, CMD_WRITE}, {10'd5, 6'h00}, 16'hDEAD, 3);
		chk(16'({flash_start, flash_erase, rewritable_read_block, cpu_stall}), 16'hA);
		chk(16'(flash_page_index), 16'd5);
		regis(CTRL_ADDR, 8'h45);
		buf_is(5'h00, 16'hFFFF);
		repeat (12) @(posedge sys_clk);
		#1 chk(16'(rewritable_read_block), 16'h0001);
		repeat (6) @(posedge sys_clk);
		#1 chk(16'(rewritable_read_block), 16'h0000);
		buf_is(5'h03, 16'hFFFF);
		regis(CTRL_ADDR, 8'h40);
		op({2'b00, CMD_LOAD}, 16'h0008, 16'h7777, 1);
		op({2'b10, CMD_RWW_EN}, 16'h0000, 16'h0000, 1);
		buf_is(5'h04, 16'hFFFF);
		regis(CTRL_ADDR, 8'h80);
		chk(16'(spm_ready_irq), 16'h0001);
		op({2'b10, CMD_ERASE}, {10'd800, 6'h00}, 16'h0000, 2);
		chk(16'({flash_start, flash_erase, rewritable_read_block, cpu_stall}), 16'hF);
		chk(16'(flash_page_index), 16'd800);
		chk(16'(spm_ready_irq), 16'h0000);
		// Five frozen edges stretch the erase by five cycles.
		@(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (5) @(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (15) @(posedge sys_clk);
		#1 chk(16'(cpu_stall), 16'h0001);
		repeat (8) @(posedge sys_clk);
		#1 chk(16'(cpu_stall), 16'h0000);
		chk(16'(spm_ready_irq), 16'h0001);
		op({2'b00, CMD_LOAD}, 16'h000A, 16'h1357, 1);
		buf_is(5'h05, 16'h1357);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		buf_is(5'h05, 16'hFFFF);
		regis(CTRL_ADDR, 8'h00);
		conclude();
	end
endmodule : tb
